// file: design/hub_cfg_pkg.sv
// package of constants for the hub configuration strap selector
// assumes a 100 MHz system clock and a wishbone classic register bus
package hub_cfg_pkg;

  // ----------------------------------------------------------------
  // configuration methods
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    METHOD_RESERVED,
    METHOD_SMBUS,
    METHOD_DEFAULTS,
    METHOD_EEPROM
  } config_method_type;

  localparam logic [1:0] STRAP_CODE_RESERVED = 2'h0;
  localparam logic [1:0] STRAP_CODE_SMBUS    = 2'h1;
  localparam logic [1:0] STRAP_CODE_DEFAULTS = 2'h2;
  localparam logic [1:0] STRAP_CODE_EEPROM   = 2'h3;

  localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2c;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int RESET_MIN_PS     = 1000000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // register map (word offsets in bytes)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS_OFFSET  = 4'h0;
  localparam logic [3:0] REG_CONTROL_OFFSET = 4'h4;

  // status fields
  localparam int STATUS_METHOD_LSB   = 0;
  localparam int STATUS_RESERVED_BIT = 2;
  localparam int STATUS_LOCAL_PWR    = 3;
  localparam int STATUS_EXT_CLK      = 4;
  localparam int STATUS_STRAP_LO     = 5;
  localparam int STATUS_STRAP_HI     = 6;
  localparam int STATUS_SMB_ADDR_LSB = 8;

  // control fields
  localparam int CONTROL_CLR_RESERVED = 0;
  localparam int CONTROL_OSC_DISABLE  = 1;

  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

endpackage

// file: design/strap_sync.sv
// two flip-flop synchroniser for a group of asynchronous pin inputs
// assumes one clock; no reset needed on the synchroniser chain
`timescale 1ns/100ps
module strap_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        meta_q[g] <= async_i[g];
        sync_o[g] <= meta_q[g];
      end
    end
  endgenerate

endmodule // strap_sync

// file: design/hub_config_strap_select.sv
// reset-time configuration method selector for a two-port hub controller
// assumes chip_reset_n_i, straps and power detect arrive asynchronously;
// the serial pins are open-drain and resolved outside; registers on classic wishbone
//
// Behaviour
// - latch both method straps at reset release and hold until next reset
// - straps hi 0 lo 1 select smbus slave at address 0101100
// - hi 1 lo 0 selects internal defaults; both 1 selects eeprom read
// - serial clock pin doubles as low strap, sampled at reset release
// - external clock select low drives crystal, high takes cmos clock; control bit 1 set turns the crystal drive off
// - local power detect high means local supply, low means bus powered
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module hub_config_strap_select (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // chip pins
  input  wire logic        chip_reset_n_i,
  input  wire logic        config_method_strap_hi_i,
  input  wire logic        serial_clk_i,
  output logic             serial_clk_o,
  output logic             serial_clk_oe_o,
  input  wire logic        serial_data_i,
  output logic             serial_data_o,
  output logic             serial_data_oe_o,
  input  wire logic        external_clock_select_i,
  input  wire logic        local_power_detect_i,
  input  wire logic        test_mode_i,
  // decoded configuration
  output logic             chip_in_reset_o,
  output logic             config_valid_o,
  output logic             smbus_slave_en_o,
  output logic [6:0]       smbus_slave_addr_o,
  output logic             eeprom_load_en_o,
  output logic             internal_defaults_o,
  output logic             reserved_strap_o,
  output logic             crystal_drive_en_o,
  output logic             external_ref_clock_sel_o,
  output logic             self_powered_o,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [4:0] pins_sync;

  strap_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_i   (clk_i),
    .async_i ({test_mode_i, local_power_detect_i, external_clock_select_i,
               serial_clk_i, config_method_strap_hi_i}),
    .sync_o  (pins_sync)
  );

  logic reset_n_s;
  logic reset_n_q;
  logic [1:0] reset_sync_q;

  always_ff @(posedge clk_i)
  begin
    reset_sync_q <= {reset_sync_q[0], chip_reset_n_i};
  end

  assign reset_n_s = reset_sync_q[1];

  // ----------------------------------------------------------------
  // reset pulse qualification
  // ----------------------------------------------------------------
  logic [7:0] low_cnt_q;
  logic       reset_seen_q;
  logic       release_evt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_cnt_q    <= 8'h00;
      reset_seen_q <= 1'b0;
    end
    else if (!reset_n_s)
    begin
      if (low_cnt_q != 8'(hub_cfg_pkg::RESET_MIN_CYCLES))
        low_cnt_q <= low_cnt_q + 8'h01;
      if (low_cnt_q == 8'(hub_cfg_pkg::RESET_MIN_CYCLES - 1))
        reset_seen_q <= 1'b1;
    end
    else
    begin
      low_cnt_q <= 8'h00;
      if (release_evt)
        reset_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reset_n_q <= 1'b0;
    else
      reset_n_q <= reset_n_s;
  end

  assign release_evt = reset_n_s && !reset_n_q && reset_seen_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chip_in_reset_o <= 1'b1;
    else if (release_evt)
      chip_in_reset_o <= 1'b0;
    else if (reset_seen_q)
      chip_in_reset_o <= 1'b1;
  end

  // ----------------------------------------------------------------
  // strap latch and method decode
  // ----------------------------------------------------------------
  hub_cfg_pkg::config_method_type method_q;
  logic [1:0] strap_q;

  function automatic hub_cfg_pkg::config_method_type decode_method(input logic [1:0] code);
    unique case (code)
      hub_cfg_pkg::STRAP_CODE_SMBUS:    decode_method = hub_cfg_pkg::METHOD_SMBUS;
      hub_cfg_pkg::STRAP_CODE_DEFAULTS: decode_method = hub_cfg_pkg::METHOD_DEFAULTS;
      hub_cfg_pkg::STRAP_CODE_EEPROM:   decode_method = hub_cfg_pkg::METHOD_EEPROM;
      hub_cfg_pkg::STRAP_CODE_RESERVED: decode_method = hub_cfg_pkg::METHOD_RESERVED;
    endcase
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_q        <= 2'h0;
      method_q       <= hub_cfg_pkg::METHOD_RESERVED;
      config_valid_o <= 1'b0;
    end
    else if (release_evt)
    begin
      strap_q        <= {pins_sync[0], pins_sync[1]};
      method_q       <= decode_method({pins_sync[0], pins_sync[1]});
      config_valid_o <= 1'b1;
    end
    else if (reset_seen_q && !reset_n_s)
      config_valid_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // reserved code flag
  // ----------------------------------------------------------------
  logic clr_reserved;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reserved_strap_o <= 1'b0;
    else if (release_evt)
      reserved_strap_o <= (decode_method({pins_sync[0], pins_sync[1]})
                           == hub_cfg_pkg::METHOD_RESERVED);
    else if (clr_reserved)
      reserved_strap_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  logic [31:0] control_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      smbus_slave_en_o    <= 1'b0;
      smbus_slave_addr_o  <= 7'h00;
      eeprom_load_en_o    <= 1'b0;
      internal_defaults_o <= 1'b0;
    end
    else
    begin
      smbus_slave_en_o    <= config_valid_o && method_q == hub_cfg_pkg::METHOD_SMBUS;
      smbus_slave_addr_o  <= hub_cfg_pkg::SMBUS_SLAVE_ADDR;
      eeprom_load_en_o    <= config_valid_o && method_q == hub_cfg_pkg::METHOD_EEPROM;
      internal_defaults_o <= config_valid_o && (method_q == hub_cfg_pkg::METHOD_DEFAULTS
                             || method_q == hub_cfg_pkg::METHOD_RESERVED);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crystal_drive_en_o       <= 1'b0;
      external_ref_clock_sel_o <= 1'b0;
      self_powered_o           <= 1'b0;
    end
    else
    begin
      crystal_drive_en_o       <= !pins_sync[2] && !control_q[hub_cfg_pkg::CONTROL_OSC_DISABLE];
      external_ref_clock_sel_o <= pins_sync[2];
      self_powered_o           <= pins_sync[3];
    end
  end

  // serial pins are always released; nothing in this module ever drives them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_clk_o     <= 1'b0;
      serial_clk_oe_o  <= 1'b0;
      serial_data_o    <= 1'b0;
      serial_data_oe_o <= 1'b0;
    end
    else
    begin
      serial_clk_o     <= 1'b0;
      serial_clk_oe_o  <= 1'b0;
      serial_data_o    <= 1'b0;
      serial_data_oe_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic req;
  logic [31:0] status_word;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign clr_reserved = req && wb_we_i && wb_adr_i == hub_cfg_pkg::REG_CONTROL_OFFSET
                        && wb_sel_i[0] && wb_dat_i[hub_cfg_pkg::CONTROL_CLR_RESERVED]
                        && !release_evt;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[hub_cfg_pkg::STATUS_METHOD_LSB +: 2] = method_q;
    status_word[hub_cfg_pkg::STATUS_RESERVED_BIT]    = reserved_strap_o;
    status_word[hub_cfg_pkg::STATUS_LOCAL_PWR]       = self_powered_o;
    status_word[hub_cfg_pkg::STATUS_EXT_CLK]         = external_ref_clock_sel_o;
    status_word[hub_cfg_pkg::STATUS_STRAP_LO]        = strap_q[0];
    status_word[hub_cfg_pkg::STATUS_STRAP_HI]        = strap_q[1];
    status_word[hub_cfg_pkg::STATUS_SMB_ADDR_LSB +: 7] = smbus_slave_addr_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      control_q <= hub_cfg_pkg::CONTROL_RESET;
    else if (req && wb_we_i && wb_adr_i == hub_cfg_pkg::REG_CONTROL_OFFSET && wb_sel_i[0])
      control_q[hub_cfg_pkg::CONTROL_OSC_DISABLE] <= wb_dat_i[hub_cfg_pkg::CONTROL_OSC_DISABLE];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          hub_cfg_pkg::REG_STATUS_OFFSET:  wb_dat_o <= status_word;
          hub_cfg_pkg::REG_CONTROL_OFFSET: wb_dat_o <= control_q;
          default:                         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // hub_config_strap_select

// file: verif/hub_cfg_checker.sv
// port assertions for the hub config strap selector
// assumes bind onto the top module, one clock, sync reset
`timescale 1ns/100ps
module hub_cfg_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       serial_clk_oe_o,
  input wire logic       serial_data_oe_o,
  input wire logic       chip_in_reset_o,
  input wire logic       config_valid_o,
  input wire logic       smbus_slave_en_o,
  input wire logic [6:0] smbus_slave_addr_o,
  input wire logic       eeprom_load_en_o,
  input wire logic       internal_defaults_o,
  input wire logic       reserved_strap_o,
  input wire logic       crystal_drive_en_o,
  input wire logic       external_ref_clock_sel_o,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_smbus_addr_fixed: assert property (
    config_valid_o |-> smbus_slave_addr_o == hub_cfg_pkg::SMBUS_SLAVE_ADDR)
    else $error("smbus address wrong");
  a_one_method: assert property (
    config_valid_o && $past(config_valid_o) |-> $onehot({smbus_slave_en_o, eeprom_load_en_o, internal_defaults_o}))
    else $error("method not one-hot");
  a_idle_no_method: assert property (
    !config_valid_o && !$past(config_valid_o) |-> !(smbus_slave_en_o || eeprom_load_en_o || internal_defaults_o))
    else $error("method enabled while invalid");
  a_clock_source: assert property (
    external_ref_clock_sel_o |-> !crystal_drive_en_o)
    else $error("crystal driven with external clock");
  a_reserved_fallback: assert property (
    $rose(reserved_strap_o) |-> ##[0:2] (internal_defaults_o && !smbus_slave_en_o && !eeprom_load_en_o))
    else $error("reserved code not on defaults");
  a_pins_released: assert property (
    !serial_clk_oe_o && !serial_data_oe_o)
    else $error("serial pin driven");
  a_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_matches_valid: assert property (
    chip_in_reset_o == !config_valid_o)
    else $error("reset flag and valid disagree");
endmodule // hub_cfg_checker

bind hub_config_strap_select hub_cfg_checker u_hub_cfg_checker (.clk_i, .rst_i, .serial_clk_oe_o,
  .serial_data_oe_o, .chip_in_reset_o, .config_valid_o, .smbus_slave_en_o, .smbus_slave_addr_o, .eeprom_load_en_o,
  .internal_defaults_o, .reserved_strap_o, .crystal_drive_en_o, .external_ref_clock_sel_o,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// file: verif/board_strap_model.sv
// board model: reset pin, straps and pulled serial pins
// assumes apply is called just after a rising clock edge
`timescale 1ns/100ps
module board_strap_model (
  input  wire logic clk_i,
  input  wire logic scl_o_i,
  input  wire logic scl_oe_i,
  input  wire logic sda_o_i,
  input  wire logic sda_oe_i,
  output logic      chip_reset_n_o,
  output logic      strap_hi_o,
  output logic      scl_pin_o,
  output logic      sda_pin_o,
  output logic      test_pin_o
);
  logic lo_q = 1'b1;
  initial chip_reset_n_o = 1'b1;
  initial strap_hi_o = 1'b1;
  assign test_pin_o = 1'b0;
  assign scl_pin_o = (scl_oe_i && !scl_o_i) ? 1'b0 : lo_q;
  assign sda_pin_o = (sda_oe_i && !sda_o_i) ? 1'b0 : 1'b1;
  task automatic apply(input logic [1:0] code, input int low_cycles);
    strap_hi_o <= code[1];
    lo_q <= code[0];
    repeat (4) @(posedge clk_i);
    chip_reset_n_o <= 1'b0;
    repeat (low_cycles) @(posedge clk_i);
    chip_reset_n_o <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask
endmodule // board_strap_model

// file: verif/hub_config_strap_select_tb.sv
// self-checking bench for the hub config strap selector
// assumes the checker and the board model compile first
`timescale 1ns/100ps
module hub_config_strap_select_tb;
  logic clk_i, rst_i, chip_reset_n_i, config_method_strap_hi_i, serial_clk_i, serial_clk_o;
  logic serial_clk_oe_o, serial_data_i, serial_data_o, serial_data_oe_o, external_clock_select_i;
  logic local_power_detect_i, test_mode_i, chip_in_reset_o, config_valid_o, smbus_slave_en_o;
  logic eeprom_load_en_o, internal_defaults_o, reserved_strap_o, crystal_drive_en_o;
  logic external_ref_clock_sel_o, self_powered_o, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [6:0]  smbus_slave_addr_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd;
  logic [31:0] exp_q[$];
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          seed = 43395;
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  hub_config_strap_select u_hub_config_strap_select (.clk_i, .rst_i, .chip_reset_n_i,
    .config_method_strap_hi_i, .serial_clk_i, .serial_clk_o, .serial_clk_oe_o, .serial_data_i,
    .serial_data_o, .serial_data_oe_o, .external_clock_select_i, .local_power_detect_i, .test_mode_i,
    .chip_in_reset_o, .config_valid_o, .smbus_slave_en_o, .smbus_slave_addr_o, .eeprom_load_en_o,
    .internal_defaults_o, .reserved_strap_o, .crystal_drive_en_o, .external_ref_clock_sel_o,
    .self_powered_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  board_strap_model u_board_strap_model (.clk_i, .scl_o_i(serial_clk_o), .scl_oe_i(serial_clk_oe_o),
    .sda_o_i(serial_data_o), .sda_oe_i(serial_data_oe_o), .chip_reset_n_o(chip_reset_n_i),
    .strap_hi_o(config_method_strap_hi_i), .scl_pin_o(serial_clk_i), .sda_pin_o(serial_data_i),
    .test_pin_o(test_mode_i));
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] status_exp(logic [1:0] c, logic f, logic sp, logic ec);
    return {17'h0, hub_cfg_pkg::SMBUS_SLAVE_ADDR, 1'b0, c[1], c[0], ec, sp, f, c};
  endfunction
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check("read data", wb_dat_o, exp_q.pop_front());
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [31:0] exp);
    if (!we)
      exp_q.push_back(exp);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial
  begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    external_clock_select_i = 1'b0;
    local_power_detect_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 3; i >= 0; i--)
    begin
      rnd = $random(seed);
      external_clock_select_i <= rnd[0];
      local_power_detect_i <= rnd[1];
      u_board_strap_model.apply(i[1:0], 110);
      check("valid", config_valid_o, 32'h1);
      check("smbus", smbus_slave_en_o, i == 1);
      check("eeprom", eeprom_load_en_o, i == 3);
      check("defaults", internal_defaults_o, i == 2 || i == 0);
      check("reserved", reserved_strap_o, i == 0);
      check("crystal", crystal_drive_en_o, !rnd[0]);
      check("power", self_powered_o, rnd[1]);
      check("in reset", chip_in_reset_o, 32'h0);
      check("serial", {serial_clk_o, serial_clk_oe_o, serial_data_o, serial_data_oe_o}, 32'h0);
      wb(1'b0, 4'h0, 32'h0, status_exp(i[1:0], i == 0, rnd[1], rnd[0]));
    end
    external_clock_select_i <= 1'b0;
    u_board_strap_model.apply(2'h1, 40);
    check("short pulse", smbus_slave_en_o, 32'h0);
    check("still valid", config_valid_o, 32'h1);
    check("flag kept", reserved_strap_o, 32'h1);
    wb(1'b1, 4'h4, 32'h1, 32'h0);
    check("flag clear", reserved_strap_o, 32'h0);
    check("crystal on", crystal_drive_en_o, 32'h1);
    wb(1'b1, 4'h4, 32'h2, 32'h0);
    wb(1'b0, 4'h4, 32'h0, 32'h2);
    check("osc off", crystal_drive_en_o, 32'h0);
    wb_sel_i <= 4'he;
    wb(1'b1, 4'h4, 32'h0, 32'h0);
    wb(1'b1, 4'h8, 32'h0, 32'h0);
    wb_sel_i <= 4'hf;
    wb(1'b0, 4'h4, 32'h0, 32'h2);
    wb(1'b0, 4'h8, 32'h0, 32'h0);
    close_out();
  end
endmodule // hub_config_strap_select_tb
